// ### hw/sinc3_pkg.sv
// Constants and carrier types for the sinc3 decimation filter
package sinc3_pkg;
  localparam int unsigned ACC_W        = 24;
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned CNT_W        = 8;
  localparam int unsigned WORD_MSB     = 23;
  localparam int unsigned WORD_LSB     = 8;
  localparam int unsigned DECIM_RATIO  = 256;
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned MOD_CLK_HZ   = 10_000_000;
  localparam int unsigned WORD_RATE_HZ = MOD_CLK_HZ / DECIM_RATIO;
  // System clocks per modulator clock period at nominal rate
  localparam int unsigned CLKS_PER_MOD = CLK_HZ / MOD_CLK_HZ;
  localparam logic [CNT_W-1:0] CNT_LAST  = 8'hFF;
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
  localparam logic [ACC_W-1:0] ACC_RESET = 24'h000000;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [ACC_W-1:0] BIT_ZERO_VAL = 24'h000000;
  localparam logic [ACC_W-1:0] BIT_ONE_VAL  = 24'h000001;

  // Link from the modulator: clock and bit travel together
  typedef struct packed {
    logic filter_sample_clock;
    logic filter_bit_in;
  } mod_link_t;

  // Decimated output word with its one-cycle strobe
  typedef struct packed {
    logic              valid;
    logic [WORD_W-1:0] data;
  } word_out_t;
endpackage : sinc3_pkg

// ### hw/sinc3_filter_module.sv
// Third-order sinc decimation filter for a one-bit modulator stream
// What this block does
// - Capture modulator bit on falling clock edge; option selects rising.
// - Three cascaded 24-bit integrators update once per modulator cycle.
// - First difference subtracts word-delayed third integrator, then saves it.
// - Reset clears all word-rate differences and delays asynchronously.
// - Output word loads third difference bits 23 down to 8.
// - Word strobe from 8-bit modulator cycle counter, modulator rate / ratio.
// - Ratio 256 at 10 MHz gives 16-bit words near 39 kHz.
`timescale 1ns/1ps
module sinc3_filter_module
  import sinc3_pkg::*;
#(
  parameter bit CAPTURE_RISING = 1'b0
) (
  input  wire logic      clk,
  input  wire logic      srst,
  input  wire mod_link_t link_in,
  output word_out_t      word_out
);

  logic             clk_s1_ff, clk_s2_ff, clk_s3_ff;
  logic             bit_s1_ff, bit_s2_ff;
  logic             sample_edge;
  logic [ACC_W-1:0] int_in;
  logic [ACC_W-1:0] acc1_ff, acc2_ff, third_integrator_ff;
  logic [ACC_W-1:0] nxt_acc1, nxt_acc2, nxt_third_integrator;
  logic [CNT_W-1:0] word_cnt_ff, nxt_word_cnt;
  logic             word_stb_ff, nxt_word_stb;
  logic [ACC_W-1:0] third_integrator_word_delay_ff;
  logic [ACC_W-1:0] first_difference_stage_ff, diff2_ff;
  logic [ACC_W-1:0] third_difference_stage_ff;
  logic [ACC_W-1:0] first_difference_stage_dly_ff, diff2_dly_ff;
  logic [ACC_W-1:0] nxt_delay, nxt_first_difference_stage, nxt_diff2, nxt_third_difference_stage;
  logic [ACC_W-1:0] nxt_first_difference_stage_dly, nxt_diff2_dly;
  logic [WORD_W-1:0] data_ff, nxt_data;
  logic             valid_ff, nxt_valid;

  // Bit value for the integrator input
  function automatic logic [ACC_W-1:0] bit_value(input logic b);
    return b ? BIT_ONE_VAL : BIT_ZERO_VAL;
  endfunction : bit_value

  // Two-stage synchronisers; clock and bit delayed alike
  always_ff @(posedge clk) begin
    if (srst) begin
      clk_s1_ff <= 1'b0;
      clk_s2_ff <= 1'b0;
      clk_s3_ff <= 1'b0;
      bit_s1_ff <= 1'b0;
      bit_s2_ff <= 1'b0;
    end else begin
      clk_s1_ff <= link_in.filter_sample_clock;
      clk_s2_ff <= clk_s1_ff;
      clk_s3_ff <= clk_s2_ff;
      bit_s1_ff <= link_in.filter_bit_in;
      bit_s2_ff <= bit_s1_ff;
    end
  end

  // Chosen modulator clock edge
  assign sample_edge = CAPTURE_RISING ? (clk_s2_ff & ~clk_s3_ff)
                                      : (~clk_s2_ff & clk_s3_ff);
  assign int_in = bit_value(bit_s2_ff);

  // Integrators and word counter next values
  always_comb begin
    nxt_acc1             = acc1_ff;
    nxt_acc2             = acc2_ff;
    nxt_third_integrator = third_integrator_ff;
    nxt_word_cnt         = word_cnt_ff;
    nxt_word_stb         = 1'b0;
    if (sample_edge) begin
      nxt_acc1             = acc1_ff + int_in;
      nxt_acc2             = acc2_ff + acc1_ff;
      nxt_third_integrator = third_integrator_ff + acc2_ff;
      nxt_word_cnt         = word_cnt_ff + 8'h01;
      nxt_word_stb         = (word_cnt_ff == CNT_LAST);
    end
  end

  // Modulator-rate registers
  always_ff @(posedge clk) begin
    if (srst) begin
      acc1_ff             <= ACC_RESET;
      acc2_ff             <= ACC_RESET;
      third_integrator_ff <= ACC_RESET;
      word_cnt_ff         <= CNT_RESET;
      word_stb_ff         <= 1'b0;
    end else begin
      acc1_ff             <= nxt_acc1;
      acc2_ff             <= nxt_acc2;
      third_integrator_ff <= nxt_third_integrator;
      word_cnt_ff         <= nxt_word_cnt;
      word_stb_ff         <= nxt_word_stb;
    end
  end

  // Differentiators and output word next values
  always_comb begin
    nxt_delay     = third_integrator_word_delay_ff;
    nxt_first_difference_stage     = first_difference_stage_ff;
    nxt_diff2     = diff2_ff;
    nxt_third_difference_stage     = third_difference_stage_ff;
    nxt_first_difference_stage_dly = first_difference_stage_dly_ff;
    nxt_diff2_dly = diff2_dly_ff;
    nxt_data      = data_ff;
    nxt_valid     = 1'b0;
    if (word_stb_ff) begin
      nxt_first_difference_stage = third_integrator_ff
                  - third_integrator_word_delay_ff;
      nxt_delay = third_integrator_ff;
      nxt_diff2 = first_difference_stage_ff - first_difference_stage_dly_ff;
      nxt_third_difference_stage = diff2_ff - diff2_dly_ff;
      nxt_first_difference_stage_dly = first_difference_stage_ff;
      nxt_diff2_dly = diff2_ff;
      nxt_data  = third_difference_stage_ff[WORD_MSB:WORD_LSB];
      nxt_valid = 1'b1;
    end
  end

  // Word-rate registers, cleared at once by reset
  always_ff @(posedge clk or posedge srst) begin
    if (srst) begin
      third_integrator_word_delay_ff <= ACC_RESET;
      first_difference_stage_ff      <= ACC_RESET;
      diff2_ff                       <= ACC_RESET;
      third_difference_stage_ff      <= ACC_RESET;
      first_difference_stage_dly_ff                   <= ACC_RESET;
      diff2_dly_ff                   <= ACC_RESET;
    end else begin
      third_integrator_word_delay_ff <= nxt_delay;
      first_difference_stage_ff      <= nxt_first_difference_stage;
      diff2_ff                       <= nxt_diff2;
      third_difference_stage_ff      <= nxt_third_difference_stage;
      first_difference_stage_dly_ff                   <= nxt_first_difference_stage_dly;
      diff2_dly_ff                   <= nxt_diff2_dly;
    end
  end

  // Output register
  always_ff @(posedge clk) begin
    if (srst) begin
      data_ff  <= WORD_RESET;
      valid_ff <= 1'b0;
    end else begin
      data_ff  <= nxt_data;
      valid_ff <= nxt_valid;
    end
  end

  // One driver for the whole output struct
  assign word_out = {valid_ff, data_ff};

  // Checks
  sequence s_word_taken;
    word_stb_ff ##1 valid_ff;
  endsequence

  // Modulator edge that takes the counter from its last value
  sequence s_wrap_edge;
    sample_edge && (word_cnt_ff == CNT_LAST);
  endsequence

  a_wrap_strobe: assert property (@(posedge clk) disable iff (srst)
    s_wrap_edge |=> word_stb_ff)
    else $error("no word strobe after counter wrap");
  a_strobe_valid: assert property (@(posedge clk) disable iff (srst)
    word_stb_ff |=> valid_ff)
    else $error("output valid missing after strobe");
  a_valid_pulse: assert property (@(posedge clk) disable iff (srst)
    valid_ff |=> !valid_ff)
    else $error("output valid longer than one cycle");
  a_data_hold: assert property (@(posedge clk) disable iff (srst)
    !valid_ff |-> $stable(data_ff))
    else $error("output word moved without valid");
  a_count_step: assert property (@(posedge clk) disable iff (srst)
    sample_edge |=> word_cnt_ff == $past(word_cnt_ff) + 8'h01)
    else $error("word counter did not advance");
  a_count_hold: assert property (@(posedge clk) disable iff (srst)
    !sample_edge |=> $stable(word_cnt_ff))
    else $error("word counter moved without edge");
  a_integ_second: assert property (@(posedge clk) disable iff (srst)
    sample_edge |=> acc2_ff == $past(acc2_ff) + $past(acc1_ff))
    else $error("second integrator did not add first");
  a_stage_hold: assert property (@(posedge clk) disable iff (srst)
    !word_stb_ff |=> $stable(first_difference_stage_ff)
      && $stable(third_difference_stage_ff) && $stable(first_difference_stage_dly_ff))
    else $error("word-rate stage moved without strobe");
  a_third_diff: assert property (@(posedge clk) disable iff (srst)
    word_stb_ff |=> third_difference_stage_ff ==
      $past(diff2_ff) - $past(diff2_dly_ff)
      && diff2_dly_ff == $past(diff2_ff))
    else $error("third difference wrong");

  a_edge_polarity: assert property (@(posedge clk) disable iff (srst)
    sample_edge |-> (clk_s2_ff == CAPTURE_RISING) && (clk_s3_ff != clk_s2_ff))
    else $error("sample edge on wrong clock polarity");
  a_integ_chain: assert property (@(posedge clk) disable iff (srst)
    sample_edge |=> third_integrator_ff ==
      $past(third_integrator_ff) + $past(acc2_ff))
    else $error("third integrator did not add second");
  a_integ_hold: assert property (@(posedge clk) disable iff (srst)
    !sample_edge |=> $stable(acc1_ff) && $stable(third_integrator_ff))
    else $error("integrator moved without modulator edge");
  a_input_map: assert property (@(posedge clk) disable iff (srst)
    sample_edge |=> acc1_ff - $past(acc1_ff) == {23'h000000, $past(bit_s2_ff)})
    else $error("bit mapped to wrong integrator input");
  a_first_diff: assert property (@(posedge clk) disable iff (srst)
    word_stb_ff |=> first_difference_stage_ff ==
      $past(third_integrator_ff) - $past(third_integrator_word_delay_ff)
      && third_integrator_word_delay_ff == $past(third_integrator_ff))
    else $error("first difference wrong");
  a_word_reset: assert property (@(posedge clk)
    srst |=> third_difference_stage_ff == ACC_RESET
      && third_integrator_word_delay_ff == ACC_RESET)
    else $error("word-rate stage not cleared by reset");
  a_output_slice: assert property (@(posedge clk) disable iff (srst)
    s_word_taken |->
      data_ff == $past(third_difference_stage_ff[WORD_MSB:WORD_LSB]))
    else $error("output word wrong slice");
  a_strobe_count: assert property (@(posedge clk) disable iff (srst)
    word_stb_ff |-> word_cnt_ff == CNT_RESET && $past(sample_edge))
    else $error("word strobe not at counter wrap");
endmodule : sinc3_filter_module

// ### verif/mod_model.sv
// Modulator model: free-running clock with a density-set bit stream
`timescale 1ns/1ps
module mod_model
  import sinc3_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       run,
  input  wire logic [3:0] half,
  input  wire logic [4:0] dens,
  output mod_link_t       link
);
  logic [3:0] ph_ff;
  // Toggle every half period; a new bit launches on each rise
  always_ff @(posedge clk) begin
    if (!run) begin
      ph_ff <= 4'h0;
      link  <= 2'h2;
    end else if (ph_ff >= half - 4'h1) begin
      ph_ff <= 4'h0;
      link.filter_sample_clock <= !link.filter_sample_clock;
      if (!link.filter_sample_clock) begin
        link.filter_bit_in <= (5'($urandom % 16) < dens);
      end
    end else begin
      ph_ff <= ph_ff + 4'h1;
    end
  end
endmodule : mod_model

// ### verif/sinc3_filter_module_test.sv
// Self-checking bench for the sinc3 decimation filter
`timescale 1ns/1ps
module sinc3_filter_module_test;
  import sinc3_pkg::*;
  logic              clk, srst, run;
  logic [3:0]        half;
  logic [4:0]        dens;
  mod_link_t         link;
  word_out_t         word_out;
  logic [ACC_W-1:0]  a1, a2, a3, a3d, f1, f2, f3, f1d, f2d;
  logic [WORD_W-1:0] expq[$];
  logic              prev_clk;
  logic              srst_q;
  int                err_count, total_checks, cnt, gap, words;
  int unsigned       seed_dummy;

  sinc3_filter_module uut (.clk(clk), .srst(srst), .link_in(link),
                           .word_out(word_out));
  mod_model partner (.clk(clk), .run(run), .half(half), .dens(dens),
                     .link(link));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  // Reference sinc3 stepped on each modulator falling edge
  always @(posedge clk) begin
    if (srst || !run) begin
      {a1, a2, a3, a3d, f1, f2, f3, f1d, f2d} = '0;
      cnt = 0;
      expq.delete();
    end else if (prev_clk && !link.filter_sample_clock) begin
      a3 = a3 + a2;
      a2 = a2 + a1;
      a1 = a1 + ACC_W'(link.filter_bit_in);
      cnt++;
      if (cnt == DECIM_RATIO) begin
        cnt = 0;
        expq.push_back(f3[WORD_MSB:WORD_LSB]);
        f3 = f2 - f2d;
        f2d = f2;
        f2 = f1 - f1d;
        f1d = f1;
        f1 = a3 - a3d;
        a3d = a3;
      end
    end
    prev_clk = link.filter_sample_clock;
    srst_q = srst;
  end

  // Output checks where values have settled
  always @(negedge clk) begin
    if (srst_q) begin
      check(32'(word_out), 32'h0);
    end else if (word_out.valid === 1'b1) begin
      if (expq.size() == 0) check(32'h1, 32'h0);
      else check(32'(word_out.data), 32'(expq.pop_front()));
      if (words > 0) check(gap, 2 * half * DECIM_RATIO);
      words++;
      gap = 1;
    end else begin
      gap++;
    end
  end

  task automatic run_test(input logic [4:0] d, input logic [3:0] h);
    int lim;
    srst <= 1'b1;
    run  <= 1'b0;
    dens <= d;
    half <= h;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    run <= 1'b1;
    words = 0;
    lim = 6 * 2 * h * DECIM_RATIO;
    while (words < 5 && lim > 0) begin
      @(posedge clk);
      lim--;
    end
    if (lim == 0) begin
      err_count++;
      results();
    end else begin
      $display("test done: density %0d/16 words %0d", d, words);
    end
  endtask : run_test

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    static logic [4:0] tab [5] = '{5'd8, 5'd13, 5'd3, 5'd16, 5'd0};
    srst = 1'b1;
    run = 1'b0;
    half = 4'h2;
    dens = 5'd8;
    seed_dummy = $urandom(32'h89A46E68);
    repeat (16) @(posedge clk);
    for (int t = 0; t < 8; t++) begin
      run_test(t < 5 ? tab[t] : 5'($urandom % 17), t == 7 ? 4'h3 : 4'h2);
    end
    results();
  end
endmodule : sinc3_filter_module_test
